// ---- rtl/dmcr_regs.sv ----
// miscellaneous control registers: gain-down step, software reset command, general-purpose io
//
// Contract
// RL1 - the gain-down step register resets to 7F and is host readable and writable at any time.
// RL2 - the six-bit down-step field is a negative two's complement value, 3F is -1 and 00 is -64.
// RL3 - the rate select bit accumulates steps once per field when 0 and once per frame when 1.
// RL4 - the accumulated down total sets how far the automatic gain value is lowered.
// RL5 - the noise-reject bit set to 1 adds a vertical check that rejects false vertical syncs.
// RL6 - any write to the software reset address returns every control register to its default.
// RL7 - a read of the software reset address returns an undefined value with no side effect.
// RL8 - the io register resets to 00 and is host accessible at any time, subject to output mode.
// RL9 - in 8-bit output mode the eight low video data pins are general-purpose io, unrelated to pixel clock.
// RL10 - register bits 7 to 4 return the levels present on video data pins 7 to 4.
// RL11 - register bits 3 to 0 written by the host are driven onto video data pins 3 to 0.
// RL12 - the io function works only when the pixel bus width select is 0.
// RL13 - outside 8-bit mode the input bits read back carry no valid information.
// RL14 - outside 8-bit mode the four output bits are forced to logical 1.
// RL15 - the host always writes 0 to the white-level compensation enable bit.
// RL16 - the io input pins are synchronised before the host can read them.
`default_nettype none
module dmcr_regs
   import dmcr_pkg::*;
#(
   parameter int ACC_WIDTH = 12
) (
   input wire logic CORE_CLK_I,
   input wire logic RSTN_I,
   input wire logic [7:0] REG_ADDR_I,
   input wire logic [7:0] REG_WDATA_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   output logic [7:0] REG_RDATA_O,
   output logic REG_RVALID_O,
   input wire logic PIXEL_BUS_WIDTH_SEL_I,
   input wire logic FIELD_TICK_I,
   input wire logic FRAME_TICK_I,
   input wire logic GAIN_CLEAR_I,
   input wire logic [7:0] VIDEO_DATA_PINS_I,
   output logic [3:0] VIDEO_DATA_PINS_O,
   output logic [7:0] VIDEO_DATA_PINS_OE_N_O,
   output logic VSYNC_NOISE_REJECT_EN_O,
   output logic ACCUM_RATE_FRAME_SEL_O,
   output logic [ACC_WIDTH-1:0] GAIN_DOWN_TOTAL_O,
   output logic SOFT_RESET_O
);
   import dmcr_pkg::*;

   logic [7:0] wgds_q;
   logic [3:0] gpio_out_q;
   logic [ACC_WIDTH-1:0] acc_q;
   logic [3:0] gpio_in_sync;
   logic soft_rst;
   logic acc_tick;
   logic [ACC_WIDTH-1:0] step_mag;
   logic eight_bit_mode;
   logic [3:0] out_view;

   if (ACC_WIDTH < 7)
   begin : g_acc_width_check
      // a full 64-step decrement needs seven bits
      $error("dmcr_regs: ACC_WIDTH must be at least 7");
   end

   function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] b);
      addr_hit = (a == b);
   endfunction : addr_hit

   // read-back word of one address; unmapped addresses read as zero
   function automatic logic [7:0] read_word(input logic [7:0] a, input logic [7:0] step_reg,
      input logic [3:0] in_nib, input logic [3:0] out_nib);
      logic [7:0] w;
      w = 8'h00;
      case (a)
         DMCR_ADDR_WGDS: w = step_reg;
         DMCR_ADDR_SRST: w = DMCR_UNDEF_READ; // RL7
         DMCR_ADDR_GPIO: w = {in_nib, out_nib}; // RL10
         default: w = 8'h00;
      endcase
      read_word = w;
   endfunction : read_word

   assign soft_rst = REG_WR_I && addr_hit(REG_ADDR_I, DMCR_ADDR_SRST); // RL6
   assign eight_bit_mode = !PIXEL_BUS_WIDTH_SEL_I; // RL12
   // field or frame pulse selects the accumulation rate
   assign acc_tick = wgds_q[DMCR_FRAME_BIT] ? FRAME_TICK_I : FIELD_TICK_I; // RL3
   // code n means n-64, so the decrement magnitude is 64-n
   assign step_mag = ACC_WIDTH'(7'h40 - {1'b0, wgds_q[DMCR_STEP_MSB:0]}); // RL2
   // output nibble as pins and read-back see it, forced high outside 8-bit mode
   assign out_view = eight_bit_mode ? gpio_out_q : DMCR_OUT_FORCED; // RL14

   // asynchronous pin inputs cross into the core clock here
   dmcr_sync #(
      .WIDTH(4)
   ) u_in_sync (
      .clk_i(CORE_CLK_I),
      .rstn_i(RSTN_I),
      .async_i(VIDEO_DATA_PINS_I[7:4]),
      .sync_o(gpio_in_sync) // RL16
   );

   always_ff @(posedge CORE_CLK_I)
   begin
      if (!RSTN_I || soft_rst)
      begin
         wgds_q <= DMCR_WGDS_RST; // RL1
      end
      else if (REG_WR_I && addr_hit(REG_ADDR_I, DMCR_ADDR_WGDS))
      begin
         wgds_q <= REG_WDATA_I; // RL1
      end
   end

   // the stored nibble is kept in any mode; only pins and read-back see the forcing
   always_ff @(posedge CORE_CLK_I)
   begin
      if (!RSTN_I || soft_rst)
      begin
         gpio_out_q <= DMCR_GPIO_RST[3:0]; // RL8
      end
      else if (REG_WR_I && addr_hit(REG_ADDR_I, DMCR_ADDR_GPIO))
      begin
         gpio_out_q <= REG_WDATA_I[3:0]; // RL11
      end
   end

   // saturating total of down steps, cleared by the gain loop
   always_ff @(posedge CORE_CLK_I)
   begin
      if (!RSTN_I || soft_rst)
      begin
         acc_q <= '0;
      end
      else if (GAIN_CLEAR_I)
      begin
         // a step that lands with the clear opens the new total instead of being lost
         acc_q <= acc_tick ? step_mag : '0;
      end
      else if (acc_tick)
      begin
         if (acc_q > ~step_mag)
         begin
            acc_q <= '1;
         end
         else
         begin
            acc_q <= acc_q + step_mag; // RL4
         end
      end
   end

   // total handed to the gain loop, one edge behind the accumulator
   always_ff @(posedge CORE_CLK_I)
   begin
      if (!RSTN_I)
      begin
         GAIN_DOWN_TOTAL_O <= '0;
      end
      else
      begin
         GAIN_DOWN_TOTAL_O <= acc_q; // RL4
      end
   end

   always_ff @(posedge CORE_CLK_I)
   begin
      if (!RSTN_I)
      begin
         VSYNC_NOISE_REJECT_EN_O <= DMCR_WGDS_RST[DMCR_NOISE_BIT];
         ACCUM_RATE_FRAME_SEL_O <= DMCR_WGDS_RST[DMCR_FRAME_BIT];
      end
      else
      begin
         VSYNC_NOISE_REJECT_EN_O <= wgds_q[DMCR_NOISE_BIT]; // RL5
         ACCUM_RATE_FRAME_SEL_O <= wgds_q[DMCR_FRAME_BIT]; // RL3
      end
   end

   always_ff @(posedge CORE_CLK_I)
   begin
      if (!RSTN_I)
      begin
         SOFT_RESET_O <= 1'b0;
      end
      else
      begin
         SOFT_RESET_O <= soft_rst; // RL6
      end
   end

   // low nibble driven, high nibble input in 8-bit mode; pixel path owns pins otherwise
   always_ff @(posedge CORE_CLK_I)
   begin
      if (!RSTN_I)
      begin
         VIDEO_DATA_PINS_O <= DMCR_OUT_FORCED;
         VIDEO_DATA_PINS_OE_N_O <= 8'hFF;
      end
      else
      begin
         VIDEO_DATA_PINS_O <= out_view; // RL11 RL14
         VIDEO_DATA_PINS_OE_N_O <= eight_bit_mode ? 8'hF0 : 8'hFF; // RL9
      end
   end

   always_ff @(posedge CORE_CLK_I)
   begin
      if (!RSTN_I)
      begin
         REG_RDATA_O <= 8'h00;
         REG_RVALID_O <= 1'b0;
      end
      else
      begin
         REG_RVALID_O <= REG_RD_I;
         if (REG_RD_I)
         begin
            // input nibble is meaningless outside 8-bit mode
            REG_RDATA_O <= read_word(REG_ADDR_I, wgds_q, gpio_in_sync, out_view); // RL10 RL13
         end
      end
   end
endmodule : dmcr_regs
`default_nettype wire

// ---- pkg/dmcr_pkg.sv ----
// shared constants for the decoder miscellaneous control register bank
`default_nettype none
package dmcr_pkg;
   localparam logic [7:0] DMCR_ADDR_WGDS = 8'h1E;
   localparam logic [7:0] DMCR_ADDR_SRST = 8'h1F;
   localparam logic [7:0] DMCR_ADDR_GPIO = 8'h3F;
   localparam logic [7:0] DMCR_WGDS_RST = 8'h7F;
   localparam logic [7:0] DMCR_GPIO_RST = 8'h00;
   localparam int DMCR_NOISE_BIT = 7;
   localparam int DMCR_FRAME_BIT = 6;
   localparam int DMCR_STEP_MSB = 5;
   localparam int DMCR_IN_LSB = 4;
   localparam int DMCR_SYNC_STAGES = 3;
   localparam logic [7:0] DMCR_UNDEF_READ = 8'h00;
   localparam logic [3:0] DMCR_OUT_FORCED = 4'hF;
endpackage : dmcr_pkg
`default_nettype wire

// ---- rtl/dmcr_sync.sv ----
// three-stage synchroniser for asynchronous pin inputs, change accepted when last two stages agree
`default_nettype none
module dmcr_sync #(
   parameter int WIDTH = 4
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;

   if (WIDTH < 1)
   begin : g_width_check
      $error("dmcr_sync: WIDTH must be at least 1");
   end

   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
      begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         sync_o <= '0;
      end
      else
      begin
         s1_q <= async_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         for (int i = 0; i < WIDTH; i++)
         begin
            if (s2_q[i] == s3_q[i])
            begin
               sync_o[i] <= s3_q[i];
            end
         end
      end
   end
endmodule : dmcr_sync
`default_nettype wire

// ---- verification/dmcr_regs_asserts.sv ----
// port assertions for the register bank
`default_nettype none
module dmcr_regs_chk (
   input wire logic CORE_CLK_I,
   input wire logic RSTN_I,
   input wire logic [7:0] REG_ADDR_I,
   input wire logic [7:0] REG_WDATA_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   input wire logic REG_RVALID_O,
   input wire logic PIXEL_BUS_WIDTH_SEL_I,
   input wire logic [3:0] VIDEO_DATA_PINS_O,
   input wire logic [7:0] VIDEO_DATA_PINS_OE_N_O,
   input wire logic SOFT_RESET_O
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge CORE_CLK_I);
   endclocking
   default disable iff (!RSTN_I);
   a_read_answer: assert property (REG_RD_I |=> REG_RVALID_O) else $error("no answer");
   a_answer_cause: assert property (REG_RVALID_O |-> $past(REG_RD_I)) else $error("stray answer");
   a_answer_once: assert property (REG_RVALID_O && !REG_RD_I |=> !REG_RVALID_O) else $error("long answer");
   a_srst_pulse: assert property (REG_WR_I && REG_ADDR_I == 8'h1F |=> SOFT_RESET_O) else $error("no reset");
   a_srst_cause: assert property (SOFT_RESET_O |-> $past(REG_WR_I) && $past(REG_ADDR_I) == 8'h1F)
      else $error("stray reset");
   a_out_forced: assert property ($past(PIXEL_BUS_WIDTH_SEL_I) |-> VIDEO_DATA_PINS_O == 4'hF)
      else $error("not forced");
   a_oe_mode: assert property ($past(RSTN_I) |-> VIDEO_DATA_PINS_OE_N_O ==
      ($past(PIXEL_BUS_WIDTH_SEL_I) ? 8'hFF : 8'hF0)) else $error("bad enables");
   a_out_write: assert property (REG_WR_I && REG_ADDR_I == 8'h3F && !PIXEL_BUS_WIDTH_SEL_I ##1
      !PIXEL_BUS_WIDTH_SEL_I |=> VIDEO_DATA_PINS_O == 4'($past(REG_WDATA_I, 2))) else $error("bad output");
endmodule : dmcr_regs_chk
bind dmcr_regs dmcr_regs_chk i_chk (.*);
`default_nettype wire

// ---- verification/dmcr_host.sv ----
// host model issuing register strobes
`default_nettype none
module dmcr_host (
   input wire logic clk_i,
   input wire logic rvalid_i,
   input wire logic [7:0] rdata_i,
   output logic [7:0] addr_o,
   output logic [7:0] wdata_o,
   output logic wr_o,
   output logic rd_o
);
   timeunit 1ns;
   timeprecision 100ps;
   initial
   begin
      {addr_o, wdata_o, wr_o, rd_o} = 18'h0;
   end
   // white compensation never set; released bus shows inverted values
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      {addr_o, wdata_o, wr_o} = {a, d, 1'b1};
      @(negedge clk_i);
      {addr_o, wdata_o, wr_o} = {~a, ~d, 1'b0};
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_i);
      {addr_o, rd_o} = {a, 1'b1};
      @(negedge clk_i);
      {addr_o, rd_o} = {~a, 1'b0};
      d = rvalid_i ? rdata_i : 8'hXX;
   endtask : rd
endmodule : dmcr_host
`default_nettype wire

// ---- verification/tb.sv ----
// self-checking bench for the register bank
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fail_count++; $display("Error %0t: got %h expected %h", $time, a, e); end end
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic CORE_CLK_I = 1'b0, RSTN_I = 1'b0, PIXEL_BUS_WIDTH_SEL_I = 1'b0;
   logic FIELD_TICK_I = 1'b0, FRAME_TICK_I = 1'b0, GAIN_CLEAR_I = 1'b0;
   logic [7:0] VIDEO_DATA_PINS_I = 8'hA0;
   logic [7:0] REG_ADDR_I, REG_WDATA_I, REG_RDATA_O, VIDEO_DATA_PINS_OE_N_O, r;
   logic REG_WR_I, REG_RD_I, REG_RVALID_O, SOFT_RESET_O, VSYNC_NOISE_REJECT_EN_O, ACCUM_RATE_FRAME_SEL_O;
   logic [3:0] VIDEO_DATA_PINS_O;
   logic [11:0] GAIN_DOWN_TOTAL_O;
   int fail_count = 0;
   int compares = 0;
   dmcr_regs i_dmcr_regs (.*);
   dmcr_host i_dmcr_host (.clk_i(CORE_CLK_I), .rvalid_i(REG_RVALID_O), .rdata_i(REG_RDATA_O),
      .addr_o(REG_ADDR_I), .wdata_o(REG_WDATA_I), .wr_o(REG_WR_I), .rd_o(REG_RD_I));
   initial forever #12.5 CORE_CLK_I = ~CORE_CLK_I;
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      i_dmcr_host.rd(a, r);
      `CHK(r, e)
   endtask : rchk
   task automatic final_report;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : final_report
   initial
   begin
      repeat (16) @(negedge CORE_CLK_I);
      RSTN_I = 1'b1;
      rchk(8'h1E, 8'h7F);
      // let the pin synchroniser fill after reset
      repeat (2) @(negedge CORE_CLK_I);
      rchk(8'h3F, 8'hA0);
      i_dmcr_host.wr(8'h3F, 8'h05);
      i_dmcr_host.wr(8'h1E, 8'hBE);
      rchk(8'h1E, 8'hBE);
      `CHK({VIDEO_DATA_PINS_O, VSYNC_NOISE_REJECT_EN_O, ACCUM_RATE_FRAME_SEL_O}, 6'h16)
      FRAME_TICK_I = 1'b1;
      @(negedge CORE_CLK_I);
      {FIELD_TICK_I, FRAME_TICK_I} = 2'b10;
      @(negedge CORE_CLK_I);
      FIELD_TICK_I = 1'b0;
      i_dmcr_host.wr(8'h20, 8'hFF);
      rchk(8'h20, 8'h00);
      `CHK(GAIN_DOWN_TOTAL_O, 12'h002)
      PIXEL_BUS_WIDTH_SEL_I = 1'b1;
      i_dmcr_host.wr(8'h3F, 8'h0A);
      `CHK({VIDEO_DATA_PINS_OE_N_O, VIDEO_DATA_PINS_O}, 12'hFFF)
      $display("io test done");
      {PIXEL_BUS_WIDTH_SEL_I, VIDEO_DATA_PINS_I} = 9'h050;
      rchk(8'h1F, 8'h00);
      rchk(8'h1E, 8'hBE);
      i_dmcr_host.wr(8'h1F, 8'h5A);
      `CHK(SOFT_RESET_O, 1'b1)
      @(negedge CORE_CLK_I);
      `CHK(SOFT_RESET_O, 1'b0)
      rchk(8'h1E, 8'h7F);
      rchk(8'h3F, 8'h50);
      `CHK(GAIN_DOWN_TOTAL_O, 12'h000)
      $display("reset test done");
      {FIELD_TICK_I, FRAME_TICK_I} = 2'b10;
      @(negedge CORE_CLK_I);
      {FIELD_TICK_I, FRAME_TICK_I} = 2'b01;
      @(negedge CORE_CLK_I);
      FRAME_TICK_I = 1'b0;
      @(negedge CORE_CLK_I);
      `CHK({ACCUM_RATE_FRAME_SEL_O, GAIN_DOWN_TOTAL_O}, 13'h1001)
      GAIN_CLEAR_I = 1'b1;
      @(negedge CORE_CLK_I);
      GAIN_CLEAR_I = 1'b0;
      @(negedge CORE_CLK_I);
      `CHK(GAIN_DOWN_TOTAL_O, 12'h000)
      $display("gain test done");
      final_report();
   end
endmodule : tb
`default_nettype wire
